// *** core/adcc_pkg.sv ***
// package: register map, field layout and timing constants of the conversion control block
package adcc_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL_FIRST = 8'h00;
    localparam logic [7:0] ADDR_CTRL_SECOND = 8'h04;
    localparam logic [7:0] ADDR_RESULT_HIGH = 8'h08;
    localparam logic [7:0] ADDR_RESULT_LOW = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
    localparam logic [7:0] ADDR_ANALOG_IN = 8'h18;
    // first control register fields
    localparam int CH_LSB = 0;
    localparam int FMT_BIT = 4;
    localparam int PWR_BIT = 5;
    localparam int BUSY_BIT = 6;
    localparam int START_BIT = 7;
    // second control register fields
    localparam int REF_LSB = 0;
    localparam int DIV_LSB = 2;
    localparam int SRC_LSB = 5;
    // interrupt status / mask fields
    localparam int DONE_BIT = 0;
    localparam int GIE_BIT = 1;
    // reset values
    localparam logic [7:0] CTRL_FIRST_RST = 8'h00;
    localparam logic [7:0] CTRL_SECOND_RST = 8'h00;
    // conversion timing in converter clock periods
    localparam logic [3:0] SAMPLE_PERIODS = 4'h4;
    localparam logic [3:0] CONVERT_PERIODS = 4'hA;
    localparam int RESULT_BITS = 10;
    localparam logic [9:0] FULL_SCALE = 10'h3FF;
    // conversion sequencer states, gray coded along the path
    typedef enum logic [1:0] {
        ADCC_IDLE = 2'b00,
        ADCC_SAMPLE = 2'b01,
        ADCC_CONVERT = 2'b11
    } adcc_state_e;
endpackage

// *** core/adcc_top.sv ***
// module: conversion control block with an AHB-Lite register slave
`timescale 1ns/1ps
module adcc_top
    import adcc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [9:0] analogSample,
    output logic converterPowered,
    output logic [3:0] channelSelect,
    output logic [2:0] inputSourceSelect,
    output logic [1:0] referenceSelect,
    output logic sampleHold,
    output logic irq
);
    import adcc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] ctrlFirst;
    logic [7:0] ctrlSecond;
    logic [9:0] result;
    logic [1:0] irqStatus;
    logic [1:0] irqMask;
    logic [9:0] sampled;
    logic startSeen;
    adcc_state_e state;
    logic [3:0] periodCount;
    logic [6:0] divCount;
    logic phaseWr;
    logic [7:0] phaseAddr;
    logic [10:0] convCycles;

    ////////////////////////////////////////////////////////////////////////////
    // bus decode: zero wait states, always OKAY
    wire addrTaken = hsel && hready && htrans[1];
    wire wrCtrlFirst = phaseWr && (phaseAddr == ADDR_CTRL_FIRST);
    wire wrCtrlSecond = phaseWr && (phaseAddr == ADDR_CTRL_SECOND);
    wire wrStatus = phaseWr && (phaseAddr == ADDR_IRQ_STATUS);
    wire wrMask = phaseWr && (phaseAddr == ADDR_IRQ_MASK);
    // limitation: hreadyout stays high with the enable low, so such transfers are dropped
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // control field views
    wire startBit = ctrlFirst[START_BIT];
    wire powerOn = ctrlFirst[PWR_BIT];
    wire fmtRight = ctrlFirst[FMT_BIT];
    wire [2:0] divSel = ctrlSecond[DIV_LSB +: 3];
    wire busy = (state != ADCC_IDLE);
    wire newStart = hwdata[START_BIT];

    // start pulse ends when a written 0 follows a seen 1
    wire startFall = wrCtrlFirst && startBit && !newStart && startSeen;
    // divider tick: count reaches 2**code - 1
    function automatic logic [6:0] div_limit(input logic [2:0] code);
        div_limit = 7'((8'h01 << code) - 8'h01);
    endfunction
    wire adcTick = (divCount >= div_limit(divSel));
    wire lastPeriod = adcTick && (periodCount == 4'h1);
    wire convDone = (state == ADCC_CONVERT) && lastPeriod && powerOn;

    ////////////////////////////////////////////////////////////////////////////
    // result byte arrangement by format bit
    function automatic logic [15:0] arrange(input logic [9:0] r, input logic right);
        arrange = right ? {6'h00, r} : {r, 6'h00};
    endfunction
    wire [15:0] resultWord = arrange(result, fmtRight);

    // read mux on the address phase, so data stands through the zero-wait data phase
    // unmapped reads return zero
    wire [7:0] rdAddr = haddr[7:0];
    wire [7:0] busyView = {ctrlFirst[7], busy, ctrlFirst[5:0]};
    wire [31:0] readMux =
        (rdAddr == ADDR_CTRL_FIRST) ? {24'h000000, busyView} :
        (rdAddr == ADDR_CTRL_SECOND) ? {24'h000000, ctrlSecond} :
        (rdAddr == ADDR_RESULT_HIGH) ? {24'h000000, resultWord[15:8]} :
        (rdAddr == ADDR_RESULT_LOW) ? {24'h000000, resultWord[7:0]} :
        (rdAddr == ADDR_IRQ_STATUS) ? {30'h0, irqStatus} :
        (rdAddr == ADDR_IRQ_MASK) ? {30'h0, irqMask} : 32'h00000000;

    ////////////////////////////////////////////////////////////////////////////
    // address phase capture
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            phaseWr <= 1'b0;
            phaseAddr <= 8'h00;
        end else if (clkEn && hready) begin
            phaseWr <= addrTaken && hwrite;
            phaseAddr <= haddr[7:0];
        end
    end

    // read data registered on the address phase
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            hrdata <= 32'h00000000;
        end else if (clkEn && hready) begin
            hrdata <= (addrTaken && !hwrite) ? readMux : 32'h00000000;
        end
    end

    // control writes; busy bit is read only, power loss returns the sequencer to idle
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ctrlFirst <= CTRL_FIRST_RST;
            ctrlSecond <= CTRL_SECOND_RST;
            irqMask <= 2'b00;
            startSeen <= 1'b0;
        end else if (clkEn) begin
            if (wrCtrlFirst) begin
                ctrlFirst <= {newStart, 1'b0, hwdata[5:0]};
                startSeen <= newStart ? startBit == 1'b0 || startSeen : 1'b0;
            end
            if (wrCtrlSecond) begin
                ctrlSecond <= hwdata[7:0];
            end
            if (wrMask) begin
                irqMask <= hwdata[1:0];
            end
        end
    end

    // sequencer: 4 sample then 10 convert periods
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= ADCC_IDLE;
            periodCount <= 4'h0;
            divCount <= 7'h00;
        end else if (clkEn) begin
            divCount <= (adcTick || !busy) ? 7'h00 : 7'(divCount + 7'h01);
            if (!powerOn) begin
                state <= ADCC_IDLE;
            end else begin
                unique case (state)
                    ADCC_IDLE: if (startFall) begin
                        state <= ADCC_SAMPLE;
                        periodCount <= SAMPLE_PERIODS;
                    end
                    ADCC_SAMPLE: if (lastPeriod) begin
                        state <= ADCC_CONVERT;
                        periodCount <= CONVERT_PERIODS;
                    end else if (adcTick) begin
                        periodCount <= 4'(periodCount - 4'h1);
                    end
                    ADCC_CONVERT: if (lastPeriod) begin
                        state <= ADCC_IDLE;
                    end else if (adcTick) begin
                        periodCount <= 4'(periodCount - 4'h1);
                    end
                    default: state <= ADCC_IDLE;
                endcase
            end
        end
    end

    // sample captured while sampling, result loaded at finish
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sampled <= 10'h000;
            result <= 10'h000;
        end else if (clkEn) begin
            if (state == ADCC_SAMPLE) begin
                sampled <= analogSample;
            end
            if (convDone) begin
                result <= sampled;
            end
        end
    end

    // helper for the length check: cycles spent so far in the convert phase
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            convCycles <= 11'h000;
        end else if (clkEn) begin
            convCycles <= (state == ADCC_CONVERT) ? 11'(convCycles + 11'h001) : 11'h000;
        end
    end

    // sticky done flag: set wins over write-one-clear; the GIE status bit is held at zero
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            irqStatus <= 2'b00;
        end else if (clkEn) begin
            irqStatus[DONE_BIT] <= convDone ||
                (irqStatus[DONE_BIT] && !(wrStatus && hwdata[DONE_BIT]));
            irqStatus[GIE_BIT] <= 1'b0;
        end
    end

    // both global and done enables needed
    assign irq = irqMask[GIE_BIT] && irqMask[DONE_BIT] && irqStatus[DONE_BIT];
    assign converterPowered = powerOn;
    assign channelSelect = ctrlFirst[CH_LSB +: 4];
    assign inputSourceSelect = ctrlSecond[SRC_LSB +: 3];
    assign referenceSelect = ctrlSecond[REF_LSB +: 2];
    assign sampleHold = (state == ADCC_SAMPLE);

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_pulse_end;
        startFall && powerOn && !busy;
    endsequence

    a_busy_rise: assert property (@(posedge ref_clk) disable iff (reset)
        s_pulse_end and clkEn |=> busy)
        else $error("busy did not rise after start pulse");
    a_busy_done: assert property (@(posedge ref_clk) disable iff (reset)
        convDone && clkEn |=> !busy && result == $past(sampled))
        else $error("result or busy wrong at finish");
    a_flag_set: assert property (@(posedge ref_clk) disable iff (reset)
        convDone && clkEn |=> irqStatus[DONE_BIT])
        else $error("done flag not set");
    a_irq_gate: assert property (@(posedge ref_clk) disable iff (reset)
        irq |-> irqMask == 2'b11 && irqStatus[DONE_BIT])
        else $error("interrupt without both enables");
    a_power_off: assert property (@(posedge ref_clk) disable iff (reset)
        !powerOn && clkEn |=> !busy)
        else $error("busy while powered down");
    // power and enable must stay up for the rest of the sample phase
    sequence s_sample_run;
        (powerOn && clkEn)[*3];
    endsequence

    a_sample_len: assert property (@(posedge ref_clk) disable iff (reset)
        $rose(sampleHold) && divSel == 3'h0 && clkEn && powerOn ##1 s_sample_run
        |-> sampleHold ##1 !sampleHold)
        else $error("sampling phase length wrong");
    a_format: assert property (@(posedge ref_clk) disable iff (reset)
        fmtRight |-> resultWord[15:10] == 6'h00 && resultWord[9:0] == result)
        else $error("right format high bits not zero");
    a_width: assert property (@(posedge ref_clk) disable iff (reset)
        !fmtRight |-> resultWord[5:0] == 6'h00 && resultWord[15:6] == result)
        else $error("left format low bits not zero");

    // sequencer holds and timing
    a_busy_hold: assert property (@(posedge ref_clk) disable iff (reset)
        busy && powerOn && clkEn && !convDone |=> busy)
        else $error("busy dropped during conversion");
    a_hold_busy: assert property (@(posedge ref_clk) disable iff (reset)
        sampleHold |-> busy)
        else $error("sampling while not busy");
    a_no_start: assert property (@(posedge ref_clk) disable iff (reset)
        !busy && !startFall && clkEn |=> !busy)
        else $error("conversion began without a start pulse");
    a_conv_len: assert property (@(posedge ref_clk) disable iff (reset)
        convDone |-> convCycles == 11'((int'(CONVERT_PERIODS) << divSel) - 1))
        else $error("convert phase length wrong");
    a_abort_quiet: assert property (@(posedge ref_clk) disable iff (reset)
        !powerOn |-> !convDone)
        else $error("conversion finished while powered down");
    a_result_keep: assert property (@(posedge ref_clk) disable iff (reset)
        !convDone && clkEn |=> $stable(result))
        else $error("result changed outside a finish");

    // request flag and interrupt level
    a_flag_hold: assert property (@(posedge ref_clk) disable iff (reset)
        irqStatus[DONE_BIT] && clkEn && !(wrStatus && hwdata[DONE_BIT]) |=> irqStatus[DONE_BIT])
        else $error("done flag lost without a clear");
    a_flag_clear: assert property (@(posedge ref_clk) disable iff (reset)
        wrStatus && hwdata[DONE_BIT] && !convDone && clkEn |=> !irqStatus[DONE_BIT])
        else $error("done flag not cleared by write one");
    a_irq_level: assert property (@(posedge ref_clk) disable iff (reset)
        irqMask == 2'b11 && irqStatus[DONE_BIT] |-> irq)
        else $error("interrupt missing with both enables");

    // bus response and clock enable freeze
    a_bus_okay: assert property (@(posedge ref_clk) disable iff (reset)
        hreadyout && !hresp)
        else $error("bus response not ready and okay");
    a_clk_freeze: assert property (@(posedge ref_clk) disable iff (reset)
        !clkEn |=> $stable(state) && $stable(ctrlFirst) && $stable(ctrlSecond) && $stable(hrdata))
        else $error("state moved while clock enable low");
endmodule

// *** bench/adcc_analog_src.sv ***
// partner model: the analog source seen by the converter, as a digital code
`timescale 1ns/1ps
module adcc_analog_src (
    input wire logic ref_clk,
    input wire logic converterPowered,
    input wire logic [9:0] level,
    output logic [9:0] analogSample
);
    logic [9:0] junk = 10'h000;
    // unpowered input shows junk, which negates itself each cycle and so stays at its start value of zero
    always_ff @(posedge ref_clk) begin
        junk <= ~junk + 10'h001;
    end
    // code is already input times 1024 over reference, 10-bit unsigned
    assign analogSample = converterPowered ? level : junk;
endmodule

// *** bench/tb.sv ***
// testbench: bus-driven conversions checked against a queue model
`timescale 1ns/1ps
module tb;
    import adcc_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [9:0] level = 10'h000;
    logic clkEn = 1'b1;
    logic [3:0] channelSelect;
    logic [2:0] inputSourceSelect;
    logic [1:0] referenceSelect;
    logic [31:0] hrdata, rd;
    logic [9:0] analogSample;
    logic hreadyout, hresp, converterPowered, sampleHold, irq;
    logic [15:0] lf = 16'h0048;
    int mismatches = 0;
    int tests_run = 0;
    int cyc = 0;
    int n;
    int expQ[$];
    always #50 ref_clk = ~ref_clk;
    adcc_top i_dut (.ref_clk(ref_clk), .reset(reset), .clkEn(clkEn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .analogSample(analogSample), .converterPowered(converterPowered),
        .channelSelect(channelSelect), .inputSourceSelect(inputSourceSelect),
        .referenceSelect(referenceSelect), .sampleHold(sampleHold), .irq(irq));
    adcc_analog_src i_src (.ref_clk(ref_clk), .converterPowered(converterPowered),
        .level(level), .analogSample(analogSample));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // one single transfer; entered and left just after a rising edge
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        hsel <= 1'b1;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        rd = hrdata;
    endtask
    task automatic tally_and_finish;
        $display("tests_run %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // full conversion: program, pulse start, time the sample phase, read back
    task automatic convert(input logic [2:0] dv, input logic fmt, input logic [9:0] v);
        logic [7:0] c;
        int e;
        c = {2'b00, 1'b1, fmt, 4'h3};
        level <= v;
        expQ.push_back(v);
        bus(ADDR_CTRL_SECOND, 1'b1, {27'h0, dv, 2'b00});
        bus(ADDR_CTRL_FIRST, 1'b1, {24'h0, c});
        bus(ADDR_CTRL_FIRST, 1'b1, {24'h0, c | 8'h80});
        bus(ADDR_CTRL_FIRST, 1'b1, {24'h0, c});
        n = 0;
        for (int k = 0; k < 2000 && !(n > 0 && sampleHold === 1'b0); k++) begin
            @(posedge ref_clk);
            if (sampleHold === 1'b1) n++;
        end
        chk(32'(n), 32'(4 << dv));
        bus(ADDR_CTRL_FIRST, 1'b0, 32'h0);
        chk({31'h0, rd[BUSY_BIT]}, 32'h1);
        do bus(ADDR_CTRL_FIRST, 1'b0, 32'h0); while (rd[BUSY_BIT] === 1'b1);
        chk({31'h0, rd[BUSY_BIT]}, 32'h0);
        e = expQ.pop_front();
        bus(ADDR_RESULT_HIGH, 1'b0, 32'h0);
        chk(rd, 32'(fmt ? e >> 8 : e >> 2));
        bus(ADDR_RESULT_LOW, 1'b0, 32'h0);
        chk(rd, 32'(fmt ? e & 255 : (e & 3) << 6));
        bus(ADDR_IRQ_STATUS, 1'b0, 32'h0);
        chk(rd, 32'h1);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // hang guard: far above the few thousand cycles the sequence needs
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        bus(ADDR_ANALOG_IN, 1'b1, 32'hFF);
        for (int i = 0; i < 7; i++) begin
            bus(8'(4 * i), 1'b0, 32'h0);
            chk(rd, 32'h0);
        end
        $display("test reset done");
        for (int i = 0; i < 7; i++) begin
            lf = lfsr_next(lf);
            convert(3'(i), i[0], lf[9:0]);
            bus(ADDR_IRQ_STATUS, 1'b1, 32'h1);
        end
        convert(3'h7, 1'b1, FULL_SCALE);
        $display("test conversions done");
        chk({31'h0, irq}, 32'h0);
        bus(ADDR_IRQ_MASK, 1'b1, 32'h1);
        repeat (2) @(posedge ref_clk);
        chk({31'h0, irq}, 32'h0);
        bus(ADDR_IRQ_MASK, 1'b1, 32'h3);
        repeat (2) @(posedge ref_clk);
        chk({31'h0, irq}, 32'h1);
        bus(ADDR_IRQ_STATUS, 1'b1, 32'h1);
        repeat (2) @(posedge ref_clk);
        chk({31'h0, irq}, 32'h0);
        $display("test interrupt done");
        // power dropped mid conversion must abort without a flag
        bus(ADDR_CTRL_FIRST, 1'b1, 32'h20);
        bus(ADDR_CTRL_FIRST, 1'b1, 32'hA0);
        bus(ADDR_CTRL_FIRST, 1'b1, 32'h20);
        bus(ADDR_CTRL_FIRST, 1'b1, 32'h00);
        @(posedge ref_clk);
        bus(ADDR_CTRL_FIRST, 1'b0, 32'h0);
        chk({31'h0, rd[BUSY_BIT]}, 32'h0);
        chk({31'h0, converterPowered}, 32'h0);
        bus(ADDR_IRQ_STATUS, 1'b0, 32'h0);
        chk(rd, 32'h0);
        $display("test power off done");
        // internal source: channel parked on an unused code first, then the reference
        bus(ADDR_CTRL_FIRST, 1'b1, 32'h28);
        bus(ADDR_CTRL_SECOND, 1'b1, 32'h81);
        @(posedge ref_clk);
        chk({28'h0, channelSelect}, 32'h8);
        chk({29'h0, inputSourceSelect}, 32'h4);
        chk({30'h0, referenceSelect}, 32'h1);
        // a write made while the clock enable is low is lost
        clkEn <= 1'b0;
        bus(ADDR_CTRL_SECOND, 1'b1, 32'h3E);
        clkEn <= 1'b1;
        bus(ADDR_CTRL_SECOND, 1'b0, 32'h0);
        chk(rd, 32'h81);
        $display("test source select done");
        // reset in mid run returns the control fields to zero
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        bus(ADDR_CTRL_SECOND, 1'b0, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, converterPowered}, 32'h0);
        $display("test mid reset done");
        tally_and_finish;
    end
endmodule
